// ---- wd_supervisor.sv ----
// Windowed watchdog reset supervisor: power-up delay, closed/open windows,
// reset pulse generation and the three-service permit output.
// Assumes sense_in is the digital comparator result, synchronous to ref_clk.
//
// Overview of operation
// - Each timeout sequence is a closed window then directly an open window.
// - Closed window starts at restart and lasts 0.8 of wd_period.
// - Open window follows and lasts 0.4 of wd_period.
// - No kick in open window gives a cpu_rst_n pulse of wd_period/40.
// - Kick during closed window asserts reset and starts a fresh sequence.
// - Without service the sequence repeats, making a reset square wave.
// - Repeating reset ends only by open-window kick or new power-up.
// - Open-window kick restarts the timer without a reset pulse.
// - Supply above threshold starts powerup delay; reset held till it ends.
// - Kicks before the powerup delay completes are ignored.
// - At powerup delay end release reset and start first closed window.
// - Supply low over 5 us forces reset and deasserts permit at once.
// - After undervoltage, kicks are ignored until a full new power-up.
// - Permit stays high whenever reset is asserted.
// - Permit goes low only after 3 consecutive open-window kicks.
// - Powerup delay equals wd_period from the same time base.
// - Permit and reset outputs are both active low.
`timescale 1ns/1ns
module wd_supervisor #(
	// Cycles per tick; the resistor-scaled time base lets the bench use a shorter tick
	parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Supply sense and host service
	input wire logic sense_in,
	input wire logic wd_kick_n,
	// Supervisor outputs
	output logic cpu_rst_n,
	output logic ctl_permit_n
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		wdt_pkg::wd_state_t mode;
		logic [17:0] tick_cnt;
		logic [5:0] ticks;
		logic [9:0] low_cnt;
		logic [1:0] good;
		wdt_pkg::sup_out_t out;
	} sup_state_t;

	localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);
	localparam logic [9:0] FILT_LAST = 10'(wdt_pkg::SENSE_FILT_CYCLES);

	sup_state_t st;
	sup_state_t next_st;
	logic kick_fall;
	logic tick;

	kick_edge u_kick (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wd_kick_n(wd_kick_n),
		.kick_fall(kick_fall)
	);

	assign tick = (st.tick_cnt == TICK_LAST);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.tick_cnt = tick ? 18'h00000 : st.tick_cnt + 18'h00001;
		if (tick) begin
			next_st.ticks = st.ticks + 6'h01;
		end
		// Supply drop filter: short glitches below threshold are tolerated
		if (sense_in) begin
			next_st.low_cnt = 10'h000;
		end else if (st.low_cnt != FILT_LAST) begin
			next_st.low_cnt = st.low_cnt + 10'h001;
		end
		unique case (st.mode)
			wdt_pkg::ST_POWERUP: begin
				// Delay only runs while supply is good; kicks are ignored here
				if (!sense_in) begin
					next_st.ticks = 6'h00;
					next_st.tick_cnt = 18'h00000;
				end else if (tick && st.ticks == wdt_pkg::POWERUP_TICKS - 6'h01) begin
					next_st.mode = wdt_pkg::ST_CLOSED;
					next_st.ticks = 6'h00;
				end
			end
			wdt_pkg::ST_CLOSED: begin
				if (kick_fall) begin
					// Early service is a fault
					next_st.mode = wdt_pkg::ST_PULSE;
					next_st.ticks = 6'h00;
					next_st.tick_cnt = 18'h00000;
				end else if (tick && st.ticks == wdt_pkg::CLOSED_TICKS - 6'h01) begin
					next_st.mode = wdt_pkg::ST_OPEN;
					next_st.ticks = 6'h00;
				end
			end
			wdt_pkg::ST_OPEN: begin
				if (kick_fall) begin
					// Good service restarts the timer silently
					next_st.mode = wdt_pkg::ST_CLOSED;
					next_st.ticks = 6'h00;
					next_st.tick_cnt = 18'h00000;
					if (st.good != wdt_pkg::GOOD_NEEDED) begin
						next_st.good = st.good + 2'h1;
					end
				end else if (tick && st.ticks == wdt_pkg::OPEN_TICKS - 6'h01) begin
					next_st.mode = wdt_pkg::ST_PULSE;
					next_st.ticks = 6'h00;
				end
			end
			wdt_pkg::ST_PULSE: begin
				// After the pulse the sequence repeats while unserviced
				if (tick && st.ticks == wdt_pkg::PULSE_TICKS - 6'h01) begin
					next_st.mode = wdt_pkg::ST_CLOSED;
					next_st.ticks = 6'h00;
				end
			end
			default: begin
				next_st.mode = wdt_pkg::ST_POWERUP;
				next_st.ticks = 6'h00;
			end
		endcase
		// Undervoltage overrides the timer from any state
		if (st.low_cnt == FILT_LAST && !sense_in) begin
			next_st.mode = wdt_pkg::ST_POWERUP;
			next_st.ticks = 6'h00;
			next_st.tick_cnt = 18'h00000;
		end
		// Outputs registered from the next mode so they follow without extra lag
		next_st.out.cpu_rst_n = (next_st.mode == wdt_pkg::ST_CLOSED) ||
			(next_st.mode == wdt_pkg::ST_OPEN);
		if (!next_st.out.cpu_rst_n) begin
			next_st.good = 2'h0;
		end
		// Permit needs three good services and never while reset is low
		next_st.out.ctl_permit_n = !(next_st.out.cpu_rst_n &&
			next_st.good == wdt_pkg::GOOD_NEEDED);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{mode: wdt_pkg::ST_POWERUP, tick_cnt: 18'h00000, ticks: 6'h00,
				low_cnt: 10'h000, good: 2'h0, out: '{cpu_rst_n: 1'b0, ctl_permit_n: 1'b1}};
		end else begin
			st <= next_st;
		end
	end

	assign cpu_rst_n = st.out.cpu_rst_n;
	assign ctl_permit_n = st.out.ctl_permit_n;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	permit_vs_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cpu_rst_n |-> ctl_permit_n) else $error("permit active during reset");

	early_kick_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st.mode == wdt_pkg::ST_CLOSED && kick_fall && sense_in) |=> !cpu_rst_n)
		else $error("early kick did not reset");

	open_kick_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st.mode == wdt_pkg::ST_OPEN && kick_fall && st.low_cnt != FILT_LAST) |=>
		cpu_rst_n && st.mode == wdt_pkg::ST_CLOSED && st.ticks == 6'h00)
		else $error("open kick mishandled");

	powerup_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st.mode == wdt_pkg::ST_POWERUP && kick_fall) |=> !cpu_rst_n)
		else $error("kick acted during power-up");

	undervolt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st.low_cnt == FILT_LAST && !sense_in) |=> !cpu_rst_n && ctl_permit_n)
		else $error("undervoltage not forcing reset");

	closed_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st.mode == wdt_pkg::ST_CLOSED && tick && st.ticks == 6'h1F && !kick_fall
		&& sense_in) |=> st.mode == wdt_pkg::ST_OPEN) else $error("closed window length");

	open_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st.mode == wdt_pkg::ST_OPEN && tick && st.ticks == 6'h0F && !kick_fall
		&& sense_in) |=> !cpu_rst_n) else $error("missing timeout pulse");

	pulse_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st.mode == wdt_pkg::ST_PULSE && tick && sense_in) |=> cpu_rst_n)
		else $error("reset pulse length wrong");

	good_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!cpu_rst_n |-> st.good == 2'h0) else $error("good count kept in reset");

	permit_count_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!ctl_permit_n |-> st.good == wdt_pkg::GOOD_NEEDED)
		else $error("permit before three services");

endmodule

// ---- wdt_pkg.sv ----
// Constants and state types for the windowed watchdog supervisor.
// Assumes a 100 MHz ref_clk; all times are converted to cycle counts here.
package wdt_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 10;
	localparam int WD_PERIOD_MS = 100;
	localparam int TICKS_PER_PERIOD = 40;
	// One tick is wd_period / 40 (2.5 ms nominal)
	localparam int TICK_CYCLES = (WD_PERIOD_MS * 1000000 / TICKS_PER_PERIOD) / CLK_NS;
	localparam logic [5:0] CLOSED_TICKS = 6'h20;
	localparam logic [5:0] OPEN_TICKS = 6'h10;
	localparam logic [5:0] PULSE_TICKS = 6'h01;
	localparam logic [5:0] POWERUP_TICKS = 6'h28;
	localparam int SENSE_FILT_NS = 5000;
	localparam int SENSE_FILT_CYCLES = SENSE_FILT_NS / CLK_NS;
	localparam logic [1:0] GOOD_NEEDED = 2'h3;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_POWERUP = 3'b000,
		ST_CLOSED = 3'b001,
		ST_OPEN = 3'b010,
		ST_PULSE = 3'b011
	} wd_state_t;

	typedef struct packed {
		logic cpu_rst_n;
		logic ctl_permit_n;
	} sup_out_t;

endpackage

// ---- kick_edge.sv ----
// Synchroniser and falling-edge detector for the service input.
// Assumes the input may change at any time relative to ref_clk.
`timescale 1ns/1ns
module kick_edge (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Service input and event
	input wire logic wd_kick_n,
	output logic kick_fall
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic fall;
	} edge_state_t;

	edge_state_t st;
	edge_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = wd_kick_n;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// Only a high-to-low transition counts as one service
		next_st.fall = st.s3 & ~st.s2;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			// Sync stages start at the idle level and the event flag clear, so no false edge
			st <= 4'hE;
		end else begin
			st <= next_st;
		end
	end

	assign kick_fall = st.fall;

	single_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		kick_fall |=> !kick_fall) else $error("kick event longer than one cycle");

endmodule

// ---- host_kick.sv ----
// Host model: turns a one-cycle request into a service pulse on wd_kick_n.
// Assumes requests arrive at least 16 cycles apart, set at the falling edge.
`timescale 1ns/1ns
module host_kick (
	// Clock
	input wire logic ref_clk,
	// Request and service line
	input wire logic kick_go,
	output logic wd_kick_n
);
	logic [3:0] low_left;
	initial begin
		wd_kick_n = 1'b1;
		low_left = 4'h0;
	end
	// Eight cycles low, well over the minimum pulse width; push-pull both ways
	always @(negedge ref_clk) begin
		if (kick_go) begin
			low_left <= 4'h8;
			wd_kick_n <= 1'b0;
		end else if (low_left != 4'h0) begin
			low_left <= low_left - 4'h1;
			wd_kick_n <= (low_left == 4'h1);
		end
	end
endmodule

// ---- tb_top.sv ----
// Testbench for the windowed watchdog supervisor with a host kick model.
// Assumes a shortened tick so every window count is kept but the run stays short.
`timescale 1ns/1ns
module tb_top;
	localparam int T = 64;
	localparam int SL = 16;
	logic ref_clk = 1'b0;
	logic rst_n;
	logic sense_in;
	logic kick_go;
	logic wd_kick_n;
	logic cpu_rst_n;
	logic ctl_permit_n;
	int bad_count = 0;
	int checks = 0;

	always #5 ref_clk = ~ref_clk;

	host_kick HOST (.ref_clk(ref_clk), .kick_go(kick_go), .wd_kick_n(wd_kick_n));
	wd_supervisor #(.TICK_CYCLES(T)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sense_in(sense_in),
		.wd_kick_n(wd_kick_n), .cpu_rst_n(cpu_rst_n), .ctl_permit_n(ctl_permit_n));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Sync and edge delays make a few cycles of slack unavoidable
	task automatic near(input int n, input int e);
		chk(32'((n > e - SL && n < e + SL) ? e : n), 32'(e));
	endtask
	task automatic wait_rst(input logic v, input int lim, output int n);
		n = 0;
		while (cpu_rst_n !== v && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	task automatic idle(input int c);
		repeat (c) @(negedge ref_clk);
	endtask
	task automatic kick;
		kick_go <= 1'b1;
		@(negedge ref_clk);
		kick_go <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_powerup;
		int n;
		idle(10 * T);
		kick;
		chk(32'(cpu_rst_n), 32'h0);
		wait_rst(1'b1, 31 * T, n);
		near(n, 30 * T);
		chk(32'(ctl_permit_n), 32'h1);
	endtask
	task automatic t_good;
		int n;
		for (int i = 0; i < 3; i++) begin
			chk(32'(ctl_permit_n), 32'h1);
			wait_rst(1'b0, 40 * T, n);
			chk(32'(n), 32'(40 * T));
			kick;
		end
		idle(8);
		chk(32'(ctl_permit_n), 32'h0);
	endtask
	task automatic t_early;
		int n;
		idle(10 * T);
		kick;
		wait_rst(1'b0, 20, n);
		near(n, 4);
		chk(32'(ctl_permit_n), 32'h1);
		wait_rst(1'b1, T + SL, n);
		near(n, T);
		idle(40 * T);
		kick;
		idle(8);
		chk(32'(ctl_permit_n), 32'h1);
	endtask
	task automatic t_silent;
		int n;
		for (int i = 0; i < 2; i++) begin
			wait_rst(1'b0, 48 * T + SL, n);
			near(n, 48 * T);
			wait_rst(1'b1, T + SL, n);
			near(n, T);
		end
	endtask
	task automatic t_brown;
		int n;
		idle(10 * T);
		sense_in <= 1'b0;
		wait_rst(1'b0, 600, n);
		near(n, 500);
		chk(32'(ctl_permit_n), 32'h1);
		idle(20);
		kick;
		idle(20);
		sense_in <= 1'b1;
		idle(10 * T);
		kick;
		wait_rst(1'b1, 31 * T, n);
		near(n, 30 * T);
	endtask

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("Mismatches %0d of %0d checks", bad_count, checks);
		if (bad_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		sense_in = 1'b1;
		kick_go = 1'b0;
		idle(20);
		rst_n <= 1'b1;
		t_powerup;
		t_good;
		t_early;
		t_silent;
		t_brown;
		tally_and_finish;
	end

	// Well above the expected run of some 360 ticks
	initial begin
		repeat (500 * T) @(negedge ref_clk);
		bad_count++;
		tally_and_finish;
	end
endmodule
